// ---- hdl/cbtm_pkg.sv ----
// package: constants and carriers for the command-bus training block
package cbtm_pkg;
    localparam int CLK_MHZ          = 250;
    localparam int REF_LONG_NS      = 250;
    localparam int REF_SHORT_NS     = 80;
    localparam int REF_LONG_CYC     = (REF_LONG_NS * CLK_MHZ) / 1000;
    localparam int REF_SHORT_CYC    = (REF_SHORT_NS * CLK_MHZ) / 1000;
    localparam int FIRST_CMD_NS     = 250;
    localparam int FIRST_CMD_CYC    = (FIRST_CMD_NS * CLK_MHZ + 999) / 1000;
    localparam int CA_W             = 6;
    localparam int REF_W            = 7;
    localparam int CNT_W            = 10;
    localparam logic [REF_W-1:0] REF_RST = 7'h4D;

    typedef struct packed {
        logic             wr_sel;
        logic             op_sel;
        logic             cbt_en;
    } cbtm_ctl_t;

    typedef struct packed {
        logic [REF_W-1:0] ref_lvl;
        logic             ca_term;
    } cbtm_fsp_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_ARMED = 3'b010,
        ST_TRAIN = 3'b100
    } cbtm_state_t;
endpackage

// ---- hdl/cbtm_sync.sv ----
// three-stage synchroniser with agree-to-change filter
`timescale 1ns/1ps
module cbtm_sync #(
    parameter int W = 1
) (
    input  wire logic         mclk,
    input  wire logic         rstn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] s1_r;
    logic [W-1:0] s2_r;
    logic [W-1:0] s3_r;

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            dout <= '0;
        end
        else
        begin
            s1_r <= din;
            s2_r <= s1_r;
            s3_r <= s2_r;
            for (int i = 0; i < W; i++)
            begin
                if (s2_r[i] == s3_r[i])
                    dout[i] <= s3_r[i];
            end
        end
    end
endmodule // cbtm_sync

// ---- hdl/cbtm_core.sv ----
// device-side command-bus training: set-point switching, reference capture, CA echo
`timescale 1ns/1ps
module cbtm_core #(
    parameter int SHORT_CYC = cbtm_pkg::REF_SHORT_CYC,
    parameter int LONG_CYC  = cbtm_pkg::REF_LONG_CYC
) (
    input  wire logic                        mclk,
    input  wire logic                        rstn,
    input  wire logic                        cke,
    input  wire logic                        cs,
    input  wire logic [cbtm_pkg::CA_W-1:0]   ca,
    input  wire logic                        dqs,
    input  wire logic [cbtm_pkg::REF_W-1:0]  dq_ref,
    input  wire logic                        term_die,
    input  wire logic                        ca_term_pad_gnd,
    input  wire cbtm_pkg::cbtm_ctl_t         ctl,
    input  wire cbtm_pkg::cbtm_fsp_t         fsp0,
    input  wire cbtm_pkg::cbtm_fsp_t         fsp1,
    output logic                             device_is_term,
    output logic                             decode_en,
    output logic                             in_training,
    output logic                             active_set_point,
    output logic                             ca_term_on,
    output logic [cbtm_pkg::REF_W-1:0]       ca_reference_level,
    output logic [cbtm_pkg::CA_W-1:0]        dq_fb,
    output logic                             dq_fb_oe
);
    logic                       cke_s;
    logic                       dqs_s;
    logic [cbtm_pkg::REF_W-1:0] dq_s;
    logic                       dqs_d_r;
    logic                       cke_d_r;
    cbtm_pkg::cbtm_state_t      state_r;
    logic                       orig_sp_r;
    logic [cbtm_pkg::REF_W-1:0] cap_r;
    logic [cbtm_pkg::REF_W-1:0] cap_prev_r;
    logic [cbtm_pkg::REF_W-1:0] tmp_ref_r;
    logic                       tmp_valid_r;
    logic [cbtm_pkg::CNT_W-1:0] settle_r;
    logic                       pend_r;
    logic                       multi_r;
    logic                       apply_now;
    logic                       strobe_edge;
    logic                       cke_fall;
    logic                       cke_rise;
    logic                       single_step;
    cbtm_pkg::cbtm_fsp_t        act_fsp;

    // cke gates decoding and training entry and exit, so it is filtered like dqs; dq follows the same delay
    cbtm_sync #(.W(1)) u_cke (.mclk(mclk), .rstn(rstn), .din(cke), .dout(cke_s));
    cbtm_sync #(.W(1)) u_dqs (.mclk(mclk), .rstn(rstn), .din(dqs), .dout(dqs_s));
    cbtm_sync #(.W(cbtm_pkg::REF_W)) u_dq (.mclk(mclk), .rstn(rstn), .din(dq_ref),
                                           .dout(dq_s));

    assign strobe_edge = dqs_s != dqs_d_r;
    assign cke_fall    = cke_d_r && !cke_s;
    assign cke_rise    = !cke_d_r && cke_s;
    assign act_fsp     = active_set_point ? fsp1 : fsp0;
    // one bit wider so that a wrap from the top code to zero is not a single step
    assign single_step = ({1'b0, cap_r} == {1'b0, cap_prev_r} + 8'h01) ||
                         ({1'b0, cap_r} + 8'h01 == {1'b0, cap_prev_r});

    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            // matches the synchroniser's reset output, so no false fall follows reset
            cke_d_r <= 1'b0;
            dqs_d_r <= 1'b0;
        end
        else
        begin
            cke_d_r <= cke_s;
            dqs_d_r <= dqs_s;
        end
    end

    // training state
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            state_r   <= cbtm_pkg::ST_IDLE;
            orig_sp_r <= 1'b0;
        end
        else
        begin
            unique case (state_r)
                cbtm_pkg::ST_IDLE:
                    if (ctl.cbt_en && cke_s)
                        state_r <= cbtm_pkg::ST_ARMED;
                cbtm_pkg::ST_ARMED:
                    if (!ctl.cbt_en)
                        state_r <= cbtm_pkg::ST_IDLE;
                    else if (cke_fall)
                    begin
                        orig_sp_r <= ctl.op_sel;
                        state_r   <= cbtm_pkg::ST_TRAIN;
                    end
                cbtm_pkg::ST_TRAIN:
                    if (cke_rise)
                        state_r <= cbtm_pkg::ST_ARMED;
                default:
                    state_r <= cbtm_pkg::ST_IDLE;
            endcase
        end
    end

    assign in_training      = state_r == cbtm_pkg::ST_TRAIN;
    assign active_set_point = in_training ? !orig_sp_r : ctl.op_sel;
    assign decode_en        = !in_training && cke_s;
    assign device_is_term   = term_die;
    // a grounded pad overrides any set-point setting
    assign ca_term_on       = act_fsp.ca_term && !ca_term_pad_gnd;

    // reference capture: every strobe edge overwrites, settle restarts
    always_ff @(posedge mclk)
    begin
        if (!rstn || !in_training)
        begin
            cap_r      <= cbtm_pkg::REF_RST;
            cap_prev_r <= cbtm_pkg::REF_RST;
            pend_r     <= 1'b0;
            multi_r    <= 1'b0;
            settle_r   <= '0;
        end
        else if (strobe_edge)
        begin
            if (!pend_r)
                cap_prev_r <= tmp_valid_r ? tmp_ref_r : act_fsp.ref_lvl;
            // a changed value under repeated strobes forces the long settle
            multi_r  <= multi_r || (pend_r && dq_s != cap_r);
            cap_r    <= dq_s;
            pend_r   <= 1'b1;
            settle_r <= '0;
        end
        else if (apply_now)
        begin
            // next capture starts from the applied value
            pend_r  <= 1'b0;
            multi_r <= 1'b0;
        end
        else if (pend_r)
            settle_r <= settle_r + 10'h001;
    end

    // temporary reference, dropped on exit
    always_ff @(posedge mclk)
    begin
        if (!rstn || !in_training)
        begin
            tmp_ref_r   <= cbtm_pkg::REF_RST;
            tmp_valid_r <= 1'b0;
        end
        else if (apply_now)
        begin
            tmp_ref_r   <= cap_r;
            tmp_valid_r <= 1'b1;
        end
    end

    // pend is cleared once the value is applied
    always_comb
    begin
        apply_now = 1'b0;
        if (pend_r && !strobe_edge)
        begin
            if (settle_r >= cbtm_pkg::CNT_W'(LONG_CYC))
                apply_now = 1'b1;
            else if (single_step && !multi_r &&
                     settle_r >= cbtm_pkg::CNT_W'(SHORT_CYC))
                apply_now = 1'b1;
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rstn)
            ca_reference_level <= cbtm_pkg::REF_RST;
        else
            ca_reference_level <= (in_training && tmp_valid_r) ? tmp_ref_r
                                                               : act_fsp.ref_lvl;
    end

    // ca echo is registered; the pins are shown as latched on this clock
    always_ff @(posedge mclk)
    begin
        if (!rstn)
        begin
            dq_fb    <= '0;
            dq_fb_oe <= 1'b0;
        end
        else
        begin
            dq_fb_oe <= in_training;
            if (in_training && cs)
                dq_fb <= ca;
        end
    end
endmodule // cbtm_core

// ---- bench/cbtm_core_assertions.sv ----
// checker: port relations of the training core
`timescale 1ns/1ps
module cbtm_chk (
    input wire logic                mclk,
    input wire logic                rstn,
    input wire logic                cs,
    input wire logic [5:0]          ca,
    input wire logic                term_die,
    input wire logic                ca_term_pad_gnd,
    input wire cbtm_pkg::cbtm_ctl_t ctl,
    input wire cbtm_pkg::cbtm_fsp_t fsp0,
    input wire cbtm_pkg::cbtm_fsp_t fsp1,
    input wire logic                device_is_term,
    input wire logic                decode_en,
    input wire logic                in_training,
    input wire logic                active_set_point,
    input wire logic                ca_term_on,
    input wire logic [6:0]          ca_reference_level,
    input wire logic [5:0]          dq_fb
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);
    // alternate group is the one not selected
    logic alt_term;
    assign alt_term = ctl.op_sel ? fsp0.ca_term : fsp1.ca_term;
    a_term_flag: assert property (device_is_term == term_die)
        else $error("terminating flag wrong");
    a_no_decode: assert property (in_training |-> !decode_en)
        else $error("decoding during training");
    a_alt_set: assert property (in_training |-> active_set_point == !ctl.op_sel)
        else $error("set point not inverted");
    a_sp_restore: assert property ($fell(in_training) |->
        active_set_point != $past(active_set_point))
        else $error("set point not restored");
    a_pad_gnd: assert property (ca_term_pad_gnd |-> !ca_term_on)
        else $error("termination on with grounded pad");
    a_term_off: assert property (in_training && !alt_term |-> !ca_term_on)
        else $error("termination on though disabled");
    a_ca_echo: assert property (in_training && cs |=> dq_fb == $past(ca))
        else $error("echo wrong");
    a_ref_drop: assert property ($fell(in_training) |-> ##[1:3]
        ca_reference_level == (ctl.op_sel ? fsp1.ref_lvl : fsp0.ref_lvl))
        else $error("reference kept after exit");
    c_entry: cover property ($rose(in_training));
    c_echo: cover property (in_training && cs);
    c_gnd: cover property (in_training && ca_term_pad_gnd);
endmodule // cbtm_chk
bind cbtm_core cbtm_chk u_chk (.*);

// ---- bench/cbtm_ctrl_model.sv ----
// partner: controller side of the training pins
`timescale 1ns/1ps
module cbtm_ctrl_model (
    input  wire logic  mclk,
    output logic       cke,
    output logic       cs,
    output logic [5:0] ca,
    output logic       dqs,
    output logic [6:0] dq_ref
);
    initial
    begin
        cke = 1'h1;
        cs = 1'h0;
        ca = 6'h0;
        dqs = 1'h0;
        dq_ref = 7'h0;
    end
    task automatic idle(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic enter();
        cke = 1'h0;
        idle(64);
    endtask
    task automatic echo(input logic [5:0] v);
        cs = 1'h1;
        ca = v;
        idle(1);
    endtask
    task automatic capture(input logic [6:0] v);
        cs = 1'h0;
        ca = ~ca;
        dq_ref = v;
        // value held static so the device may not miss the first edge
        repeat (4)
        begin
            dqs = ~dqs;
            idle(4);
        end
        dq_ref = ~v;
        idle(24);
    endtask
    // static single step: short settle lands well before the long one would
    task automatic step(input logic [6:0] v);
        dq_ref = v;
        repeat (4)
        begin
            dqs = ~dqs;
            idle(4);
        end
        idle(8);
    endtask
    task automatic exit();
        cs = 1'h0;
        idle(4);
        cke = 1'h1;
        idle(12);
    endtask
endmodule // cbtm_ctrl_model

// ---- bench/tb_command_bus_training_multirank.sv ----
// testbench: training entry, echo, reference capture, exit
`timescale 1ns/1ps
module tb_command_bus_training_multirank;
    logic                mclk, rstn, term_die, ca_term_pad_gnd, cke, cs, dqs;
    logic                device_is_term, decode_en, in_training;
    logic                active_set_point, ca_term_on, dq_fb_oe;
    logic [5:0]          ca, dq_fb;
    logic [6:0]          dq_ref, ca_reference_level, v, org;
    cbtm_pkg::cbtm_ctl_t ctl;
    cbtm_pkg::cbtm_fsp_t fsp0, fsp1;
    int                  n_mismatch, checks_done, seed;
    logic [5:0]          exp_q[$];
    cbtm_core #(.SHORT_CYC(4), .LONG_CYC(8)) dut (.*);
    cbtm_ctrl_model pm (.*);
    initial
    begin
        mclk = 1'h0;
        forever #2 mclk = ~mclk;
    end
    task automatic check(input logic [6:0] seen, input logic [6:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_mismatch++;
            $display("CHECK FAILED %0t: saw %h want %h", $time, seen, want);
        end
    endtask
    task automatic tally_and_finish();
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    always @(posedge mclk)
    begin
        if (rstn && in_training && cs)
        begin
            @(negedge mclk);
            check(dq_fb, exp_q.pop_front());
        end
    end
    initial
    begin
        #20000;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        seed = 32'h826E3251;
        {rstn, term_die, ca_term_pad_gnd, ctl, fsp0, fsp1} = '0;
        pm.idle(6);
        rstn = 1'h1;
        pm.idle(6);
        for (int i = 0; i < 2; i++)
        begin
            term_die = 1'($random(seed));
            ca_term_pad_gnd = i[0];
            fsp0 = 8'($random(seed));
            fsp1 = 8'($random(seed));
            ctl = {1'h1, i[0], 1'h1};
            org = i ? fsp1.ref_lvl : fsp0.ref_lvl;
            pm.idle(8);
            check(device_is_term, term_die);
            pm.enter();
            check(active_set_point, !i[0]);
            check(decode_en, 1'h0);
            check(in_training, 1'h1);
            check(dq_fb_oe, 1'h1);
            check(ca_term_on, (i ? fsp0.ca_term : fsp1.ca_term) && !ca_term_pad_gnd);
            for (int k = 0; k < 6; k++)
            begin
                v = 7'($random(seed));
                exp_q.push_back(v[5:0]);
                pm.echo(v[5:0]);
            end
            v = 7'($random(seed));
            pm.capture(v);
            check(ca_reference_level, v);
            pm.step(v ^ 7'h01);
            check(ca_reference_level, v ^ 7'h01);
            pm.exit();
            check(active_set_point, i[0]);
            check(in_training, 1'h0);
            check(dq_fb_oe, 1'h0);
            check(ca_term_on, (i ? fsp1.ca_term : fsp0.ca_term) && !ca_term_pad_gnd);
            check(decode_en, 1'h1);
            check(ca_reference_level, org);
            pm.capture(~v);
            check(ca_reference_level, org);
        end
        tally_and_finish();
    end
endmodule // tb_command_bus_training_multirank
